// ===== include/swc_defs.vh
/*
 sleep and wake-up control: register offsets, field positions, reset values and timing counts.
 assumes inclusion by swc_sleep_ctrl and the testbench; avalon address is a word index.
*/
// Functional notes
// - only the power-down instruction enters sleep
// - entry: watchdog cleared, flags updated, oscillator off
// - io pins hold their drive state in sleep
// - watchdog reset never drives master clear pin
// - wake on master clear, watchdog, or interrupt
// - master clear wake resets; others continue execution
// - power-down flag set by power-up, cleared by sleep
// - timeout flag cleared on watchdog wake-up
// - sleep prefetches instruction at pc plus one
// - interrupt wakes only if its enable set
// - interrupt wake ignores global enable
// - global enable clear: continue in line
// - global enable set: execute next, then vector
// - pending enabled flag at sleep wakes at once
// - watchdog cleared on every wake-up
// - crystal modes wait 1024 tosc; rc none
// - instruction cycle is four tosc steps
// - watchdog timeout resets in run, wakes asleep
// - flags set regardless of enables
`ifndef SWC_DEFS_VH
`define SWC_DEFS_VH

`define SWC_AW 3
`define SWC_REG_STATUS 3'h0
`define SWC_REG_IRQ_EN 3'h1
`define SWC_REG_IRQ_FLAG 3'h2
`define SWC_REG_CONFIG 3'h3
`define SWC_REG_WDT_LIMIT 3'h4

`define SWC_ST_PWRDN 0
`define SWC_ST_TIMEOUT 1
`define SWC_ST_ASLEEP 2
`define SWC_ST_OSC_ON 3

`define SWC_IRQ_EXT 0
`define SWC_IRQ_PORT 1
`define SWC_IRQ_CMP 2
`define SWC_IRQ_GLOBAL 7

`define SWC_CFG_WDT_EN 0
`define SWC_CFG_OSC_RC 1
`define SWC_CFG_EDGE_RISE 2

`define SWC_IRQ_EN_RST 8'h00
`define SWC_CFG_RST 8'h01
`define SWC_WDT_LIMIT_RST 16'h4650
`define SWC_VECTOR_ADDR 13'h0004

`define SWC_CLK_NS 8
`define SWC_TOSC_NS 8
`define SWC_OST_TOSC 1024
`define SWC_INSTR_TOSC 4
`define SWC_WDT_TICK_NS 1000

`endif

// ===== hdl/swc_sync2.v
/*
 two flip-flop synchroniser for pins entering the sys_clk domain.
 assumes the input is a level, not a short pulse.
*/
`timescale 1ns/100ps
module swc_sync2
#(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
)
(
    sys_clk,
    rst,
    din,
    dout
);
input wire sys_clk;
input wire rst;
input wire [W-1:0] din;
output reg [W-1:0] dout;

reg [W-1:0] meta_ff;

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        meta_ff <= INIT;
        dout <= INIT;
    end
    else
    begin
        meta_ff <= din;
        dout <= meta_ff;
    end
end
endmodule // swc_sync2

// ===== hdl/swc_tick_div.v
/*
 enable divider: one-cycle tick every DIV cycles while run is high.
 assumes DIV of at least 1.
*/
`timescale 1ns/100ps
module swc_tick_div
#(
    parameter DIV = 4,
    parameter CW = 16
)
(
    sys_clk,
    rst,
    run,
    tick
);
input wire sys_clk;
input wire rst;
input wire run;
output wire tick;

localparam integer LAST_I = DIV - 1;
localparam [CW-1:0] LAST = LAST_I[CW-1:0];
reg [CW-1:0] cnt_ff;

assign tick = run && (cnt_ff == LAST);

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
        cnt_ff <= {CW{1'b0}};
    else if (!run || tick)
        cnt_ff <= {CW{1'b0}};
    else
        cnt_ff <= cnt_ff + 1'b1;
end
endmodule // swc_tick_div

// ===== hdl/swc_sleep_ctrl.v
/*
 power-down entry and wake-up sequencer with watchdog, interrupt flags and avalon-mm registers.
 assumes core decode pulses on sys_clk; master clear and ext irq are asynchronous pins.
*/
`timescale 1ns/100ps
`include "swc_defs.vh"
module swc_sleep_ctrl
#(
    parameter PCW = 13,
    parameter WDT_DIV = (`SWC_WDT_TICK_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS
)
(
    sys_clk,
    rst,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_readdata,
    avs_waitrequest,
    sleep_exec,
    clrwdt_exec,
    core_pc,
    master_clear_pin_n,
    ext_irq_pin,
    port_change_evt,
    cmp_evt,
    osc_drive_en,
    core_cycle_en,
    core_rst,
    io_hold,
    fetch_valid,
    fetch_addr,
    resume_pulse,
    vector_pulse,
    vector_addr
);
input wire sys_clk;
input wire rst;
input wire [`SWC_AW-1:0] avs_address;
input wire avs_read;
input wire avs_write;
input wire [31:0] avs_writedata;
output reg [31:0] avs_readdata;
output wire avs_waitrequest;
input wire sleep_exec;
input wire clrwdt_exec;
input wire [PCW-1:0] core_pc;
input wire master_clear_pin_n;
input wire ext_irq_pin;
input wire port_change_evt;
input wire cmp_evt;
output reg osc_drive_en;
output wire core_cycle_en;
output reg core_rst;
output reg io_hold;
output reg fetch_valid;
output reg [PCW-1:0] fetch_addr;
output reg resume_pulse;
output reg vector_pulse;
output reg [PCW-1:0] vector_addr;

localparam integer OST_CYC =
    (`SWC_OST_TOSC * `SWC_TOSC_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS;
localparam integer INSTR_CYC =
    (`SWC_INSTR_TOSC * `SWC_TOSC_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS;
localparam integer OST_LAST_I = OST_CYC - 1;
localparam [10:0] OST_LAST = OST_LAST_I[10:0];

localparam [2:0] S_RUN = 3'h0;
localparam [2:0] S_SLEEP = 3'h1;
localparam [2:0] S_OST = 3'h2;
localparam [2:0] S_ALIGN = 3'h3;
localparam [2:0] S_EXEC = 3'h4;
localparam [2:0] S_VECT = 3'h5;

// pin synchronisers
wire [1:0] pin_sync;
swc_sync2 #(.W(2), .INIT(2'b11)) u_pin_sync
(
    .sys_clk(sys_clk),
    .rst(rst),
    .din({ext_irq_pin, master_clear_pin_n}),
    .dout(pin_sync)
);
wire master_clear_low = !pin_sync[0];
wire ext_lvl = pin_sync[1];

// instruction-cycle and watchdog enables
reg [2:0] state_ff;
reg [2:0] nxt_state;
wire instr_tick;
wire wdt_tick;
swc_tick_div #(.DIV(INSTR_CYC), .CW(4)) u_instr_div
(
    .sys_clk(sys_clk),
    .rst(rst),
    .run(osc_drive_en),
    .tick(instr_tick)
);
swc_tick_div #(.DIV(WDT_DIV), .CW(16)) u_wdt_div
(
    .sys_clk(sys_clk),
    .rst(rst),
    .run(1'b1),
    .tick(wdt_tick)
);
assign core_cycle_en = instr_tick && (state_ff == S_RUN);

// registers
reg [7:0] irq_en_ff;
reg [2:0] irq_flag_ff;
reg [7:0] cfg_ff;
reg [15:0] wdt_limit_ff;
reg power_down_flag_ff;
reg to_ff;
reg ack_ff;
reg ext_prev_ff;
reg [15:0] wdt_cnt_ff;
reg [10:0] ost_cnt_ff;

wire wdt_en = cfg_ff[`SWC_CFG_WDT_EN];
wire osc_rc = cfg_ff[`SWC_CFG_OSC_RC];
wire global_irq_enable = irq_en_ff[`SWC_IRQ_GLOBAL];
wire bus_req = avs_read || avs_write;
wire bus_do = bus_req && ack_ff;
wire wr_do = avs_write && ack_ff;
assign avs_waitrequest = bus_req && !ack_ff;

// event detection
wire ext_edge = cfg_ff[`SWC_CFG_EDGE_RISE] ? (ext_lvl && !ext_prev_ff)
                                          : (!ext_lvl && ext_prev_ff);
wire [2:0] irq_set = {cmp_evt, port_change_evt, ext_edge};
wire [2:0] irq_en_vec = {irq_en_ff[`SWC_IRQ_CMP], irq_en_ff[`SWC_IRQ_PORT],
                         irq_en_ff[`SWC_IRQ_EXT]};
wire irq_wake = |(irq_en_vec & irq_flag_ff);
wire wdt_timeout = wdt_en && wdt_tick && (wdt_cnt_ff >= wdt_limit_ff);
wire sleep_go = (state_ff == S_RUN) && sleep_exec;
wire wake_now = (state_ff == S_SLEEP) && (wdt_timeout || irq_wake);
wire wdt_clear = sleep_go || wake_now || clrwdt_exec;
wire wdt_reset = wdt_timeout && (state_ff == S_RUN) && !sleep_exec;

// bus handshake and readback
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        ack_ff <= 1'b0;
        avs_readdata <= 32'h00000000;
    end
    else
    begin
        ack_ff <= bus_req && !ack_ff;
        if (avs_read && !ack_ff)
        begin
            case (avs_address)
                `SWC_REG_STATUS:
                    avs_readdata <= {28'h0000000, osc_drive_en, (state_ff == S_SLEEP),
                                     to_ff, power_down_flag_ff};
                `SWC_REG_IRQ_EN:
                    avs_readdata <= {24'h000000, irq_en_ff};
                `SWC_REG_IRQ_FLAG:
                    avs_readdata <= {29'h00000000, irq_flag_ff};
                `SWC_REG_CONFIG:
                    avs_readdata <= {24'h000000, cfg_ff};
                `SWC_REG_WDT_LIMIT:
                    avs_readdata <= {16'h0000, wdt_limit_ff};
                default:
                    avs_readdata <= 32'h00000000;
            endcase
        end
    end
end

// software registers and interrupt flags
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        irq_en_ff <= `SWC_IRQ_EN_RST;
        irq_flag_ff <= 3'h0;
        cfg_ff <= `SWC_CFG_RST;
        wdt_limit_ff <= `SWC_WDT_LIMIT_RST;
        ext_prev_ff <= 1'b1;
    end
    else
    begin
        ext_prev_ff <= ext_lvl;
        if (master_clear_low)
        begin
            irq_en_ff <= `SWC_IRQ_EN_RST;
        end
        else if (wr_do && avs_address == `SWC_REG_IRQ_EN)
        begin
            irq_en_ff <= avs_writedata[7:0];
        end
        if (wr_do && avs_address == `SWC_REG_CONFIG)
        begin
            cfg_ff <= avs_writedata[7:0];
        end
        if (wr_do && avs_address == `SWC_REG_WDT_LIMIT)
        begin
            wdt_limit_ff <= avs_writedata[15:0];
        end
        if (wr_do && avs_address == `SWC_REG_IRQ_FLAG)
            irq_flag_ff <= (irq_flag_ff & ~avs_writedata[2:0]) | irq_set;
        else
            irq_flag_ff <= irq_flag_ff | irq_set;
    end
end

// watchdog counter, runs on its own tick even asleep
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
        wdt_cnt_ff <= 16'h0000;
    else if (wdt_clear || !wdt_en || master_clear_low || wdt_timeout)
        wdt_cnt_ff <= 16'h0000;
    else if (wdt_tick)
        wdt_cnt_ff <= wdt_cnt_ff + 16'h0001;
end

// next-state logic
always @*
begin
    nxt_state = state_ff;
    case (state_ff)
        S_RUN:
        begin
            if (sleep_exec)
                nxt_state = irq_wake ? S_OST : S_SLEEP;
        end
        S_SLEEP:
        begin
            if (wdt_timeout || irq_wake)
                nxt_state = S_OST;
        end
        S_OST:
        begin
            if (osc_rc || ost_cnt_ff == OST_LAST)
                nxt_state = S_ALIGN;
        end
        S_ALIGN:
        begin
            if (instr_tick)
                nxt_state = S_EXEC;
        end
        S_EXEC:
        begin
            if (instr_tick)
                nxt_state = global_irq_enable ? S_VECT : S_RUN;
        end
        S_VECT:
        begin
            if (instr_tick)
                nxt_state = S_RUN;
        end
        default:
            nxt_state = S_RUN;
    endcase
    if (master_clear_low)
        nxt_state = S_RUN;
end

// sequencer, flags and core-facing outputs
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        state_ff <= S_RUN;
        power_down_flag_ff <= 1'b1;
        to_ff <= 1'b1;
        osc_drive_en <= 1'b1;
        io_hold <= 1'b0;
        core_rst <= 1'b1;
        ost_cnt_ff <= 11'h000;
        fetch_valid <= 1'b0;
        fetch_addr <= {PCW{1'b0}};
        resume_pulse <= 1'b0;
        vector_pulse <= 1'b0;
        vector_addr <= {PCW{1'b0}};
    end
    else
    begin
        state_ff <= nxt_state;
        fetch_valid <= 1'b0;
        resume_pulse <= 1'b0;
        vector_pulse <= 1'b0;
        // internal reset only; master clear pin is never driven
        core_rst <= master_clear_low || wdt_reset;
        if (wdt_reset)
            to_ff <= 1'b0;
        if (clrwdt_exec && state_ff == S_RUN)
        begin
            to_ff <= 1'b1;
            power_down_flag_ff <= 1'b1;
        end
        if (state_ff == S_OST)
            ost_cnt_ff <= ost_cnt_ff + 11'h001;
        else
            ost_cnt_ff <= 11'h000;
        if (master_clear_low)
        begin
            osc_drive_en <= 1'b1;
            io_hold <= 1'b0;
        end
        else
        begin
            case (state_ff)
                S_RUN:
                begin
                    if (sleep_exec)
                    begin
                        power_down_flag_ff <= 1'b0;
                        to_ff <= 1'b1;
                        osc_drive_en <= irq_wake;
                        io_hold <= !irq_wake;
                        fetch_valid <= 1'b1;
                        fetch_addr <= core_pc + {{(PCW-1){1'b0}}, 1'b1};
                    end
                end
                S_SLEEP:
                begin
                    io_hold <= 1'b1;
                    if (wdt_timeout)
                        to_ff <= 1'b0;
                    if (wdt_timeout || irq_wake)
                        osc_drive_en <= 1'b1;
                end
                S_ALIGN:
                begin
                    io_hold <= 1'b0;
                end
                S_EXEC:
                begin
                    if (instr_tick)
                        resume_pulse <= 1'b1;
                end
                S_VECT:
                begin
                    if (instr_tick)
                    begin
                        vector_pulse <= 1'b1;
                        vector_addr <= `SWC_VECTOR_ADDR;
                    end
                end
                default:
                begin
                    osc_drive_en <= 1'b1;
                end
            endcase
        end
    end
end
endmodule // swc_sleep_ctrl

// ===== tb/swc_sleep_ctrl_sva.sv
/*
 checker for swc_sleep_ctrl: sleep entry, resume, vector and reset relations.
 assumes binding to the design with its PCW value.
*/
`timescale 1ns/100ps
module swc_sleep_ctrl_chk
#(
    parameter PCW = 13
)
(
    input wire sys_clk,
    input wire rst,
    input wire sleep_exec,
    input wire [PCW-1:0] core_pc,
    input wire master_clear_pin_n,
    input wire osc_drive_en,
    input wire core_cycle_en,
    input wire core_rst,
    input wire io_hold,
    input wire fetch_valid,
    input wire [PCW-1:0] fetch_addr,
    input wire resume_pulse,
    input wire vector_pulse,
    input wire [PCW-1:0] vector_addr
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
sequence entry_s;
    sleep_exec && !io_hold && !core_rst;
endsequence
fetch_addr_a: assert property (entry_s |=> fetch_valid && fetch_addr == $past(core_pc) + 1'b1)
    else $error("prefetch address wrong");
fetch_cause_a: assert property (fetch_valid |-> $past(sleep_exec))
    else $error("sleep entered without instruction");
hold_entry_a: assert property (entry_s |=> io_hold == !osc_drive_en)
    else $error("pins not held at sleep");
osc_hold_a: assert property (!osc_drive_en |-> io_hold)
    else $error("oscillator off while pins free");
vec_addr_a: assert property (vector_pulse |-> vector_addr == 13'h0004)
    else $error("vector address wrong");
vec_order_a: assert property (vector_pulse |-> $past(resume_pulse, 4))
    else $error("vector not four cycles after resume");
pin_rst_a: assert property (!master_clear_pin_n [*5] |-> core_rst)
    else $error("pin low without core reset");
tick_gap_a: assert property (core_cycle_en |=> !core_cycle_en [*3])
    else $error("instruction cycle shorter than four");
resume_run_a: assert property (resume_pulse |-> !core_rst && osc_drive_en)
    else $error("resume while reset or oscillator off");
cover property (resume_pulse);
cover property (vector_pulse);
cover property (fetch_valid);
cover property (core_rst ##1 !core_rst);
endmodule // swc_sleep_ctrl_chk
bind swc_sleep_ctrl swc_sleep_ctrl_chk #(.PCW(PCW)) swc_sleep_ctrl_chk_inst (.sys_clk, .rst,
    .sleep_exec, .core_pc, .master_clear_pin_n, .osc_drive_en, .core_cycle_en, .core_rst,
    .io_hold, .fetch_valid, .fetch_addr, .resume_pulse, .vector_pulse, .vector_addr);

// ===== tb/swc_pins_model.sv
/*
 pin and event model: master clear pin, external irq pin, peripheral events.
 assumes tasks are called right after a rising edge of sys_clk.
*/
`timescale 1ns/100ps
module swc_pins_model
(
    input wire sys_clk,
    output logic master_clear_pin_n,
    output logic ext_irq_pin,
    output logic port_change_evt,
    output logic cmp_evt
);
initial
begin
    master_clear_pin_n = 1'b1;
    ext_irq_pin = 1'b1;
    port_change_evt = 1'b0;
    cmp_evt = 1'b0;
end
task pulse(input logic port);
    @(posedge sys_clk);
    if (port)
        port_change_evt <= 1'b1;
    else
        cmp_evt <= 1'b1;
    @(posedge sys_clk);
    port_change_evt <= 1'b0;
    cmp_evt <= 1'b0;
endtask
task ext_edge;
    @(posedge sys_clk);
    ext_irq_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext_irq_pin <= 1'b1;
endtask
task hold_reset_pin(input int cyc);
    @(posedge sys_clk);
    master_clear_pin_n <= 1'b0;
    repeat (cyc) @(posedge sys_clk);
    master_clear_pin_n <= 1'b1;
endtask
endmodule // swc_pins_model

// ===== tb/testbench.sv
/*
 self-checking bench for swc_sleep_ctrl over avalon-mm with a pin model.
 assumes include/ on the include path; watchdog divider shortened to 2.
*/
`timescale 1ns/100ps
`include "swc_defs.vh"
module testbench;
logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, sleep_exec = 0, clrwdt_exec = 0;
logic [2:0] avs_address = 0;
logic [31:0] avs_writedata = 0, avs_readdata, rd;
logic [12:0] core_pc = 0, fetch_addr, vector_addr;
logic avs_waitrequest, master_clear_pin_n, ext_irq_pin, port_change_evt, cmp_evt;
logic osc_drive_en, core_cycle_en, core_rst, io_hold, fetch_valid, resume_pulse, vector_pulse;
int failures = 0, num_checks = 0, n;
initial forever #4 sys_clk = ~sys_clk;
swc_pins_model swc_pins_model_inst (.sys_clk, .master_clear_pin_n, .ext_irq_pin,
    .port_change_evt, .cmp_evt);
swc_sleep_ctrl #(.WDT_DIV(2)) swc_sleep_ctrl_inst (.sys_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_exec,
    .clrwdt_exec, .core_pc, .master_clear_pin_n, .ext_irq_pin, .port_change_evt,
    .cmp_evt, .osc_drive_en, .core_cycle_en, .core_rst, .io_hold, .fetch_valid, .fetch_addr,
    .resume_pulse, .vector_pulse, .vector_addr);
task give_verdict;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        failures++;
    end
endtask
task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
endtask
task sleep(input logic [12:0] pc);
    @(posedge sys_clk);
    sleep_exec <= 1'b1;
    core_pc <= pc;
    @(posedge sys_clk);
    sleep_exec <= 1'b0;
    @(posedge sys_clk);
    chk({19'h0, fetch_addr}, {19'h0, pc + 13'h1});
    chk({31'h0, fetch_valid}, 32'h1);
endtask
task wake(input int lim);
    n = 0;
    while (resume_pulse !== 1'b1 && n < lim)
    begin
        @(posedge sys_clk);
        n++;
    end
endtask
task t_reset;
    logic [31:0] exp [6] = '{32'hb, 32'h0, 32'h0, 32'h1, 32'h4650, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
        bus(1'b0, i[2:0], 32'h0);
        chk(rd, exp[i]);
    end
endtask
task t_irq_gie;
    bus(1'b1, `SWC_REG_CONFIG, 32'h0);
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h82);
    sleep(13'h0123);
    bus(1'b0, `SWC_REG_STATUS, 32'h0);
    chk(rd, 32'h6);
    chk({31'h0, io_hold}, 32'h1);
    swc_pins_model_inst.pulse(1'b1);
    wake(1100);
    chk({31'h0, n >= 1020 && n <= 1044}, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, vector_pulse}, 32'h1);
    chk({19'h0, vector_addr}, 32'h4);
endtask
task t_masked_rc;
    bus(1'b1, `SWC_REG_CONFIG, 32'h2);
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h1);
    sleep(13'h1fff);
    swc_pins_model_inst.pulse(1'b0);
    wake(200);
    chk(n, 32'd200);
    bus(1'b0, `SWC_REG_IRQ_FLAG, 32'h0);
    chk(rd, 32'h6);
    swc_pins_model_inst.ext_edge;
    wake(40);
    chk({31'h0, n < 24}, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, vector_pulse}, 32'h0);
endtask
task t_pending;
    sleep(13'h0040);
    wake(40);
    chk({31'h0, n < 24}, 32'h1);
endtask
task t_wdt;
    bus(1'b1, `SWC_REG_IRQ_FLAG, 32'h7);
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h0);
    bus(1'b1, `SWC_REG_WDT_LIMIT, 32'h10);
    bus(1'b1, `SWC_REG_CONFIG, 32'h3);
    sleep(13'h0000);
    wake(300);
    chk({31'h0, n >= 24 && n <= 60}, 32'h1);
    bus(1'b0, `SWC_REG_STATUS, 32'h0);
    chk(rd, 32'h8);
    n = 0;
    while (core_rst !== 1'b1 && n < 200)
    begin
        @(posedge sys_clk);
        n++;
    end
    chk({31'h0, n >= 16 && n <= 60}, 32'h1);
    bus(1'b1, `SWC_REG_CONFIG, 32'h2);
endtask
task t_wdt_wake;
    bus(1'b1, `SWC_REG_WDT_LIMIT, 32'h40);
    bus(1'b1, `SWC_REG_IRQ_FLAG, 32'h7);
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h2);
    bus(1'b1, `SWC_REG_CONFIG, 32'h3);
    @(posedge sys_clk);
    clrwdt_exec <= 1'b1;
    @(posedge sys_clk);
    clrwdt_exec <= 1'b0;
    bus(1'b0, `SWC_REG_STATUS, 32'h0);
    chk(rd, 32'hb);
    sleep(13'h0100);
    repeat (40) @(posedge sys_clk);
    swc_pins_model_inst.pulse(1'b1);
    wake(40);
    chk({31'h0, n < 24}, 32'h1);
    n = 0;
    while (core_rst !== 1'b1 && n < 300)
    begin
        @(posedge sys_clk);
        n++;
    end
    chk({31'h0, n >= 100 && n <= 140}, 32'h1);
    bus(1'b1, `SWC_REG_CONFIG, 32'h2);
endtask
task t_master_clear_pin;
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h80);
    sleep(13'h0000);
    swc_pins_model_inst.hold_reset_pin(8);
    chk({31'h0, core_rst}, 32'h1);
    repeat (6) @(posedge sys_clk);
    bus(1'b0, `SWC_REG_IRQ_EN, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `SWC_REG_STATUS, 32'h0);
    chk(rd, 32'ha);
endtask
initial
begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_irq_gie;
    t_masked_rc;
    t_pending;
    t_wdt;
    t_wdt_wake;
    t_master_clear_pin;
    give_verdict;
end
initial
begin
    #400000;
    failures++;
    give_verdict;
end
endmodule // testbench
